/* include/wheel_decoder_pkg.sv */
package wheel_decoder_pkg;

    typedef logic [7:0] byte_type;
    typedef logic [2:0] pin_code_type;
    typedef logic [2:0] filter_n_type;

    typedef enum logic [1:0] {
        load_idle,
        load_copy
    } load_state_type;

endpackage : wheel_decoder_pkg

/* include/wheel_decoder_regs.svh */
// Notes on behaviour
// - Each phase takes one of eight pins via its own three-bit select code.
// - Mode bit: zero common, one double accuracy; double accuracy after reset.
// - Common mode with shuttle clear counts one only when a single phase edge leaves both phases at matching levels.
// - Double accuracy counts one on every phase edge, two per wheel step.
// - Live counter has no bus path; only the snapshot is readable.
// - Snapshot changes only on a software load request or a snapshot read, never by itself.
// - Writing one to load bit copies live counter into snapshot register.
// - Load bit returns to zero by itself once the copy has completed.
// - Reading the snapshot clears it unless a copy lands in that cycle; it holds counted pulse edges.
// - Decoder reset bit clears the live counter to zero.
// - Levels shorter than 2^(n+1) times 3 slow periods are jitter.
// - Polarity bit sets idle level: zero rests low, one rests high.
// - Shuttle bit lets the decoder accept non-overlapping phase pulses.
// - Whole decoder runs on the slow clock so it counts in suspend.
// - Phase inputs sampled every 2^n slow clock periods, n from filter field.
// - After reset channel A selects code 0, channel B code 1.
`ifndef WHEEL_DECODER_REGS_SVH
`define WHEEL_DECODER_REGS_SVH

`define OFS_COUNT_SNAPSHOT 8'hD0
`define OFS_FILTER_CFG 8'hD1
`define OFS_PHASE_A_SEL 8'hD2
`define OFS_PHASE_B_SEL 8'hD3
`define OFS_RESERVED_CTRL 8'hD6
`define OFS_COUNT_MODE 8'hD7
`define OFS_LOAD_TRIGGER 8'hD8
`define OFS_DECODER_RESET 8'h60

`define RST_COUNT_SNAPSHOT 8'h00
`define RST_FILTER_CFG 8'h00
`define RST_PHASE_A_SEL 3'h0
`define RST_PHASE_B_SEL 3'h1
`define RST_COUNT_MODE 1'h1

`define POS_FILTER_LO 0
`define POS_FILTER_HI 2
`define POS_POLARITY 4
`define POS_SHUTTLE 5
`define POS_SELECT_HI 2
`define POS_DOUBLE_MODE 0
`define POS_LOAD 0
`define POS_DECODER_RESET 5

`define STABLE_SAMPLES 3'h6

`endif

/* rtl/phase_filter.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wheel_decoder_regs.svh"

module phase_filter
    import wheel_decoder_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control
    input wire logic sample_tick,
    input wire logic clear,
    // Phase
    input wire logic raw_level,
    output logic level_ff
);

    logic [2:0] stable_cnt_ff;

    // New level accepted after six agreeing samples
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stable_cnt_ff <= 3'h0;
            level_ff <= 1'b0;
        end else if (clear) begin
            stable_cnt_ff <= 3'h0;
            level_ff <= 1'b0;
        end else if (sample_tick) begin
            if (raw_level == level_ff) begin
                stable_cnt_ff <= 3'h0;
            end else if (stable_cnt_ff == `STABLE_SAMPLES - 3'h1) begin
                stable_cnt_ff <= 3'h0;
                level_ff <= raw_level;
            end else begin
                stable_cnt_ff <= stable_cnt_ff + 3'h1;
            end
        end
    end

endmodule : phase_filter
`default_nettype wire

/* rtl/wheel_decoder.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wheel_decoder_regs.svh"

module wheel_decoder
    import wheel_decoder_pkg::*;
(
    // Slow clock and reset
    input wire logic clock,
    input wire logic rst,

    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata_ff,

    // Candidate phase pins, bit order pd7 pd6 pc3 pc2 pb7 pb6 pa3 pa2
    input wire logic [7:0] phase_pins
);

    // Direction of a single-phase change in quadrature order
    function automatic logic step_is_up(
        input logic pa,
        input logic pb,
        input logic ca,
        input logic cb
    );
        logic up;
        up = 1'b0;
        if (ca != pa) begin
            up = (ca != pb);
        end else begin
            up = (cb == pa);
        end
        return up;
    endfunction : step_is_up

    // Low n bits set
    function automatic logic [6:0] tick_mask(input filter_n_type n);
        logic [6:0] m;
        m = 7'h00;
        for (int i = 0; i < 7; i++) begin
            if (i < int'(n)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : tick_mask

    // Register state
    filter_n_type filter_n_ff;
    logic polarity_ff;
    logic shuttle_ff;
    pin_code_type sel_a_ff;
    pin_code_type sel_b_ff;
    logic reserved_bit_ff;
    logic double_mode_ff;
    logic decoder_reset_ff;
    byte_type count_snapshot_ff;
    load_state_type load_state_ff;

    // Pin synchronisers
    logic [7:0] sync1_ff;
    logic [7:0] sync2_ff;
    logic [7:0] sync3_ff;
    logic [7:0] pin_level_ff;

    // Sampling and decoding
    logic [6:0] prescale_ff;
    logic sample_tick_ff;
    logic raw_a_ff;
    logic raw_b_ff;
    logic phase_a;
    logic phase_b;
    logic prev_a_ff;
    logic prev_b_ff;
    byte_type live_step_counter_ff;

    // Write decode
    logic wr_cfg;
    logic wr_sel_a;
    logic wr_sel_b;
    logic wr_rsvd;
    logic wr_mode;
    logic wr_load;
    logic wr_reset;
    logic rd_snapshot;

    assign wr_cfg = wr && (addr == `OFS_FILTER_CFG);
    assign wr_sel_a = wr && (addr == `OFS_PHASE_A_SEL);
    assign wr_sel_b = wr && (addr == `OFS_PHASE_B_SEL);
    assign wr_rsvd = wr && (addr == `OFS_RESERVED_CTRL);
    assign wr_mode = wr && (addr == `OFS_COUNT_MODE);
    assign wr_load = wr && (addr == `OFS_LOAD_TRIGGER) && wdata[`POS_LOAD];
    assign wr_reset = wr && (addr == `OFS_DECODER_RESET);
    assign rd_snapshot = rd && (addr == `OFS_COUNT_SNAPSHOT);

    // Filter, polarity and shuttle configuration
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // Fields cut from the register's reset byte
            filter_n_ff <= filter_n_type'(`RST_FILTER_CFG >> `POS_FILTER_LO);
            polarity_ff <= 1'(`RST_FILTER_CFG >> `POS_POLARITY);
            shuttle_ff <= 1'(`RST_FILTER_CFG >> `POS_SHUTTLE);
        end else if (wr_cfg) begin
            filter_n_ff <= wdata[`POS_FILTER_HI:`POS_FILTER_LO];
            polarity_ff <= wdata[`POS_POLARITY];
            shuttle_ff <= wdata[`POS_SHUTTLE];
        end
    end

    // Pin selects
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sel_a_ff <= `RST_PHASE_A_SEL;
            sel_b_ff <= `RST_PHASE_B_SEL;
        end else begin
            if (wr_sel_a) begin
                sel_a_ff <= wdata[`POS_SELECT_HI:0];
            end
            if (wr_sel_b) begin
                sel_b_ff <= wdata[`POS_SELECT_HI:0];
            end
        end
    end

    // Mode, reserved and decoder reset bits
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            double_mode_ff <= `RST_COUNT_MODE;
            reserved_bit_ff <= 1'b0;
            decoder_reset_ff <= 1'b0;
        end else begin
            if (wr_mode) begin
                double_mode_ff <= wdata[`POS_DOUBLE_MODE];
            end
            if (wr_rsvd) begin
                reserved_bit_ff <= wdata[0];
            end
            if (wr_reset) begin
                decoder_reset_ff <= wdata[`POS_DECODER_RESET];
            end
        end
    end

    // Three-stage pin synchronisers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
            sync3_ff <= 8'h00;
        end else begin
            sync1_ff <= phase_pins;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // Level moves only where stages two and three agree
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_level_ff <= 8'h00;
        end else begin
            pin_level_ff <= (sync2_ff & sync3_ff)
                | (pin_level_ff & (sync2_ff | sync3_ff));
        end
    end

    // Pin select and idle polarity
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            raw_a_ff <= 1'b0;
            raw_b_ff <= 1'b0;
        end else begin
            raw_a_ff <= pin_level_ff[sel_a_ff] ^ polarity_ff;
            raw_b_ff <= pin_level_ff[sel_b_ff] ^ polarity_ff;
        end
    end

    // Sampling tick every 2^n slow periods
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prescale_ff <= 7'h00;
            sample_tick_ff <= 1'b0;
        end else begin
            prescale_ff <= prescale_ff + 7'h01;
            sample_tick_ff <= (prescale_ff & tick_mask(filter_n_ff))
                == tick_mask(filter_n_ff);
        end
    end

    phase_filter filter_a (
        .clock(clock),
        .rst(rst),
        .sample_tick(sample_tick_ff),
        .clear(decoder_reset_ff),
        .raw_level(raw_a_ff),
        .level_ff(phase_a)
    );

    phase_filter filter_b (
        .clock(clock),
        .rst(rst),
        .sample_tick(sample_tick_ff),
        .clear(decoder_reset_ff),
        .raw_level(raw_b_ff),
        .level_ff(phase_b)
    );

    // Step decision
    logic a_moved;
    logic b_moved;
    logic one_moved;
    logic quad_up;
    logic do_count;
    logic count_up;

    assign a_moved = phase_a != prev_a_ff;
    assign b_moved = phase_b != prev_b_ff;
    assign one_moved = a_moved ^ b_moved;
    assign quad_up = step_is_up(prev_a_ff, prev_b_ff, phase_a, phase_b);

    always_comb begin
        do_count = 1'b0;
        count_up = 1'b0;
        if (shuttle_ff) begin
            // A pulse counts up, B pulse counts down
            count_up = a_moved;
            if (double_mode_ff) begin
                do_count = one_moved;
            end else begin
                do_count = one_moved && (phase_a || phase_b);
            end
        end else if (double_mode_ff) begin
            do_count = one_moved;
            count_up = quad_up;
        end else begin
            do_count = one_moved && (phase_a == phase_b);
            count_up = quad_up;
        end
    end

    // Previous filtered phases
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prev_a_ff <= 1'b0;
            prev_b_ff <= 1'b0;
        end else begin
            prev_a_ff <= phase_a;
            prev_b_ff <= phase_b;
        end
    end

    // Live counter, never on the read path
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            live_step_counter_ff <= 8'h00;
        end else if (decoder_reset_ff) begin
            live_step_counter_ff <= 8'h00;
        end else if (do_count) begin
            if (count_up) begin
                live_step_counter_ff <= live_step_counter_ff + 8'h01;
            end else begin
                live_step_counter_ff <= live_step_counter_ff - 8'h01;
            end
        end
    end

    // Load sequencer; load bit reads one until the copy is done
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            load_state_ff <= load_idle;
        end else begin
            case (load_state_ff)
                load_idle: begin
                    if (wr_load) begin
                        load_state_ff <= load_copy;
                    end
                end
                load_copy: begin
                    // A request landing in the completing cycle is kept
                    if (wr_load) begin
                        load_state_ff <= load_copy;
                    end else begin
                        load_state_ff <= load_idle;
                    end
                end
                default: begin
                    load_state_ff <= load_idle;
                end
            endcase
        end
    end

    // Snapshot: copy wins over read clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_snapshot_ff <= `RST_COUNT_SNAPSHOT;
        end else if (load_state_ff == load_copy) begin
            count_snapshot_ff <= live_step_counter_ff;
        end else if (rd_snapshot) begin
            count_snapshot_ff <= 8'h00;
        end
    end

    // Read data, one cycle after the strobe
    byte_type nxt_rdata;

    always_comb begin
        nxt_rdata = 8'h00;
        case (addr)
            `OFS_COUNT_SNAPSHOT: nxt_rdata = count_snapshot_ff;
            `OFS_FILTER_CFG: begin
                nxt_rdata[`POS_FILTER_HI:`POS_FILTER_LO] = filter_n_ff;
                nxt_rdata[`POS_POLARITY] = polarity_ff;
                nxt_rdata[`POS_SHUTTLE] = shuttle_ff;
            end
            `OFS_PHASE_A_SEL: nxt_rdata[`POS_SELECT_HI:0] = sel_a_ff;
            `OFS_PHASE_B_SEL: nxt_rdata[`POS_SELECT_HI:0] = sel_b_ff;
            `OFS_RESERVED_CTRL: nxt_rdata[0] = reserved_bit_ff;
            `OFS_COUNT_MODE: nxt_rdata[`POS_DOUBLE_MODE] = double_mode_ff;
            `OFS_LOAD_TRIGGER: begin
                nxt_rdata[`POS_LOAD] = (load_state_ff != load_idle);
            end
            `OFS_DECODER_RESET: nxt_rdata[`POS_DECODER_RESET] = decoder_reset_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

endmodule : wheel_decoder
`default_nettype wire

/* verif/wheel_decoder_properties.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wheel_decoder_regs.svh"

module wheel_decoder_properties (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata_ff,
    // Phase pins
    input wire logic [7:0] phase_pins
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    rdata_quiet_a: assert property (!$past(rd) |-> rdata_ff == 8'h00)
        else $error("read data not idle");
    unmapped_zero_a: assert property (rd && !(addr inside {`OFS_COUNT_SNAPSHOT,
        `OFS_FILTER_CFG, `OFS_PHASE_A_SEL, `OFS_PHASE_B_SEL, `OFS_RESERVED_CTRL,
        `OFS_COUNT_MODE, `OFS_LOAD_TRIGGER, `OFS_DECODER_RESET}) |=> rdata_ff == 8'h00)
        else $error("unmapped read not zero");
    select_width_a: assert property (rd && (addr == `OFS_PHASE_A_SEL
        || addr == `OFS_PHASE_B_SEL) |=> rdata_ff[7:3] == 5'h00)
        else $error("select upper bits set");
    select_store_a: assert property (wr && addr == `OFS_PHASE_A_SEL ##1
        rd && addr == `OFS_PHASE_A_SEL |=> rdata_ff[2:0] == $past(wdata[2:0], 2))
        else $error("select code not kept");
    mode_width_a: assert property (rd && addr == `OFS_COUNT_MODE
        |=> rdata_ff[7:1] == 7'h00)
        else $error("mode upper bits set");
    filter_width_a: assert property (rd && addr == `OFS_FILTER_CFG
        |=> rdata_ff[7:6] == 2'h0 && !rdata_ff[3])
        else $error("filter unused bits set");
    load_pending_a: assert property (wr && addr == `OFS_LOAD_TRIGGER && wdata[0] ##1
        rd && addr == `OFS_LOAD_TRIGGER |=> rdata_ff == 8'h01)
        else $error("load bit not pending");
    load_done_a: assert property (wr && addr == `OFS_LOAD_TRIGGER && wdata[0] ##1
        !(wr && addr == `OFS_LOAD_TRIGGER) ##1 rd && addr == `OFS_LOAD_TRIGGER
        |=> rdata_ff == 8'h00)
        else $error("load bit stuck");
    read_clear_a: assert property (!$past(wr && addr == `OFS_LOAD_TRIGGER)
        && rd && addr == `OFS_COUNT_SNAPSHOT ##1 rd && addr == `OFS_COUNT_SNAPSHOT
        |=> rdata_ff == 8'h00)
        else $error("snapshot not cleared by read");
endmodule : wheel_decoder_properties

bind wheel_decoder wheel_decoder_properties u_props (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff), .phase_pins(phase_pins));

`default_nettype wire

/* verif/wheel_decoder_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wheel_decoder_regs.svh"

module wheel_decoder_tb_top
    import wheel_decoder_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    byte_type addr = 8'h00;
    byte_type wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    byte_type rdata_ff;
    byte_type phase_pins;
    logic start = 1'b0;
    logic dir = 1'b0;
    byte_type edges = 8'h00;
    byte_type gap = 8'h10;
    logic jitter = 1'b0;
    logic idle_high = 1'b0;
    pin_code_type a_code = 3'h0;
    pin_code_type b_code = 3'h1;
    logic busy;
    int fail_count = 0;
    int checked = 0;
    byte_type ofs [8] = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD6, 8'hD7, 8'hD8, 8'h55};
    byte_type dflt [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00};

    always #5 clock = ~clock;

    wheel_decoder uut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata_ff(rdata_ff), .phase_pins(phase_pins));

    wheel_encoder partner (.clock(clock), .start(start), .dir(dir), .edges(edges),
        .gap(gap), .jitter(jitter), .idle_high(idle_high), .a_code(a_code),
        .b_code(b_code), .busy(busy), .phase_pins(phase_pins));

    task automatic give_verdict();
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input byte_type got, input byte_type exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input byte_type a, input byte_type d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    task automatic rd_chk(input byte_type a, input byte_type e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk(rdata_ff, e);
    endtask : rd_chk

    task automatic load();
        wr_reg(`OFS_LOAD_TRIGGER, 8'h01);
        rd_chk(`OFS_LOAD_TRIGGER, 8'h01);
        rd_chk(`OFS_LOAD_TRIGGER, 8'h00);
    endtask : load

    task automatic steps(input logic d, input byte_type n, input byte_type g);
        dir <= d;
        edges <= n;
        gap <= g;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        @(posedge clock);
        for (int i = 0; busy; i++) begin
            if (i == 3000) begin
                fail_count++;
                give_verdict();
            end
            @(posedge clock);
        end
    endtask : steps

    task automatic dec_reset();
        wr_reg(`OFS_DECODER_RESET, 8'h20);
        wr_reg(`OFS_DECODER_RESET, 8'h00);
    endtask : dec_reset

    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd_chk(ofs[i], dflt[i]);
        end
        steps(1'b1, 8'h04, 8'h10);
        load();
        rd_chk(`OFS_COUNT_SNAPSHOT, 8'h04);
        rd_chk(`OFS_COUNT_SNAPSHOT, 8'h00);
        steps(1'b1, 8'h04, 8'h10);
        rd_chk(`OFS_COUNT_SNAPSHOT, 8'h00);
        load();
        rd_chk(`OFS_COUNT_SNAPSHOT, 8'h08);
        dec_reset();
        load();
        rd_chk(`OFS_COUNT_SNAPSHOT, 8'h00);
        wr_reg(`OFS_COUNT_MODE, 8'h00);
        rd_chk(`OFS_COUNT_MODE, 8'h00);
        steps(1'b0, 8'h04, 8'h10);
        load();
        rd_chk(`OFS_COUNT_SNAPSHOT, 8'hFE);
        a_code <= 3'h6;
        b_code <= 3'h3;
        idle_high <= 1'b1;
        wr_reg(`OFS_PHASE_A_SEL, 8'h06);
        rd_chk(`OFS_PHASE_A_SEL, 8'h06);
        wr_reg(`OFS_PHASE_B_SEL, 8'h03);
        wr_reg(`OFS_FILTER_CFG, 8'h10);
        wr_reg(`OFS_COUNT_MODE, 8'h01);
        dec_reset();
        steps(1'b1, 8'h04, 8'h10);
        load();
        rd_chk(`OFS_COUNT_SNAPSHOT, 8'h04);
        // Common mode would take an accepted glitch as one step down
        wr_reg(`OFS_FILTER_CFG, 8'h11);
        wr_reg(`OFS_COUNT_MODE, 8'h00);
        jitter <= 1'b1;
        repeat (8) @(posedge clock);
        jitter <= 1'b0;
        repeat (40) @(posedge clock);
        load();
        rd_chk(`OFS_COUNT_SNAPSHOT, 8'h04);
        steps(1'b1, 8'h04, 8'h1E);
        load();
        rd_chk(`OFS_COUNT_SNAPSHOT, 8'h06);
        // Lone A pulse in shuttle mode counts one step up
        wr_reg(`OFS_FILTER_CFG, 8'h31);
        jitter <= 1'b1;
        repeat (30) @(posedge clock);
        jitter <= 1'b0;
        repeat (30) @(posedge clock);
        load();
        rd_chk(`OFS_COUNT_SNAPSHOT, 8'h07);
        rd_chk(`OFS_DECODER_RESET, 8'h00);
        give_verdict();
    end
endmodule : wheel_decoder_tb_top

`default_nettype wire

/* verif/wheel_encoder.sv */
`timescale 1ns/1ns
`default_nettype none

module wheel_encoder
    import wheel_decoder_pkg::*;
(
    // Clock
    input wire logic clock,
    // Stroke request
    input wire logic start,
    input wire logic dir,
    input wire byte_type edges,
    input wire byte_type gap,
    // Pin setup
    input wire logic jitter,
    input wire logic idle_high,
    input wire pin_code_type a_code,
    input wire pin_code_type b_code,
    // Status and pins
    output logic busy,
    output var byte_type phase_pins
);
    logic [1:0] quad_ff = 2'h0;
    byte_type left_ff = 8'h00;
    byte_type wait_ff = 8'h00;
    logic noise_ff = 1'b0;

    always_ff @(posedge clock) begin
        noise_ff <= ~noise_ff;
    end

    // Every level held gap+1 cycles before the next edge
    always_ff @(posedge clock) begin
        if (start) begin
            left_ff <= edges;
            wait_ff <= gap;
        end else if (wait_ff != 8'h00) begin
            wait_ff <= wait_ff - 8'h01;
        end else if (left_ff != 8'h00) begin
            quad_ff <= dir ? quad_ff + 2'h1 : quad_ff - 2'h1;
            left_ff <= left_ff - 8'h01;
            wait_ff <= gap;
        end
    end

    assign busy = (left_ff != 8'h00) || (wait_ff != 8'h00);

    // Unselected pins toggle so a wrong pin choice shows
    always_comb begin
        phase_pins = {4{noise_ff, ~noise_ff}};
        // Chosen pins are inputs only at the decoder; this model is their sole driver
        phase_pins[a_code] = quad_ff[1] ^ quad_ff[0] ^ jitter ^ idle_high;
        phase_pins[b_code] = quad_ff[1] ^ idle_high;
    end
endmodule : wheel_encoder

`default_nettype wire
